/* File: hdl/pmc_power_mgmt_cap.sv */
/*
  Power management capability register pair of the configuration space:
  a fixed capabilities word and a control/status word with wake status,
  wake enable, data selector and power state.
  Assumes a single-cycle configuration access port on clk_sys, with wake
  events and command bits coming from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pmc_power_mgmt_cap (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Configuration access port
  input wire logic [7:0] cfgAddr,
  input wire logic cfgRdEn,
  input wire logic cfgWrEn,
  input wire logic [3:0] cfgByteEn,
  input wire logic [31:0] cfgWrData,
  output logic [31:0] cfgRdData_q,
  output logic cfgAck_q,
  // Wake detection and command register
  input wire logic wakeEvent,
  input wire logic cmdMagicBit18,
  input wire logic cmdMagicBit19,
  input wire logic powerResume,
  // Power control outputs
  output logic wakeReq_b_q,
  output logic [1:0] powerState_q,
  output logic wakeEnable_q,
  output logic [3:0] dataSelector_q
);
  // ==========================================================================
  // State
  typedef struct packed {
    logic [31:0] rdData;      // Read return word
    logic ack;                // Access answer
    logic wakeReq_b;          // Wake output, active low
    logic [1:0] powerState;   // Present power state
    logic wakeEnable;         // Wake assertion enable
    logic [3:0] dataSelector; // Storage only
  } pmc_state_s;

  pmc_state_s state_q;  // Registered state
  pmc_state_s state_d;  // Next state

  pmc_flag_if wakeFlag ();  // Wake status carrier

  logic ctrlHit;       // Access aimed at control/status word
  logic ctrlWrite;     // Write to control/status word
  logic magicDefault;  // Command forces magic wake
  logic [31:0] capWord;
  logic [31:0] ctrlWord;

  // ==========================================================================
  // Wake status flag
  pmc_sticky_flag uWakeFlag (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .flagIf(wakeFlag)
  );

  // Decode
  assign ctrlHit = (cfgAddr == pmc_pkg::PM_CONTROL_STATUS_OFS);
  assign ctrlWrite = cfgWrEn && ctrlHit;
  assign magicDefault = cmdMagicBit18 && cmdMagicBit19;

  // Wake event sets status whatever the enable holds
  assign wakeFlag.setReq = wakeEvent;
  // Only a one written in the status bit clears it
  assign wakeFlag.clrReq = ctrlWrite && cfgByteEn[1]
    && cfgWrData[pmc_pkg::WAKE_STATUS_BIT];

  // ==========================================================================
  // Fixed capabilities word
  assign capWord = {
    pmc_pkg::WAKE_STATE_SUPPORT,
    pmc_pkg::DEEPER_SLEEP_SUPPORTED,
    pmc_pkg::LIGHT_SLEEP_SUPPORTED,
    pmc_pkg::AUX_SUPPLY_CURRENT,
    pmc_pkg::SPECIAL_INIT_NEEDED,
    1'b0,                              // Reserved
    pmc_pkg::WAKE_NEEDS_BUS_CLOCK,
    pmc_pkg::PM_SPEC_REVISION,
    pmc_pkg::NEXT_CAPABILITY_LINK,
    pmc_pkg::CAPABILITY_CODE
  };

  // Control/status word as read
  assign ctrlWord = {
    16'h0000,                          // Reserved
    wakeFlag.flag,
    pmc_pkg::DATA_SCALING_VALUE,
    state_q.dataSelector,
    state_q.wakeEnable,
    6'h00,                             // Reserved
    state_q.powerState
  };

  // ==========================================================================
  // Next state
  always_comb
  begin
    state_d = state_q;
    state_d.ack = cfgRdEn || cfgWrEn;
    // Read mux, unmapped offsets return zero
    if (cfgRdEn)
    begin
      case (cfgAddr)
        pmc_pkg::PM_CAPABILITIES_OFS:
        begin
          state_d.rdData = capWord;
        end
        pmc_pkg::PM_CONTROL_STATUS_OFS:
        begin
          state_d.rdData = ctrlWord;
        end
        default:
        begin
          state_d.rdData = 32'h00000000;
        end
      endcase
    end
    // Byte 1: selector and enable
    if (ctrlWrite && cfgByteEn[1])
    begin
      state_d.dataSelector = cfgWrData[pmc_pkg::DATA_SELECTOR_LSB +: 4];
      state_d.wakeEnable = cfgWrData[pmc_pkg::WAKE_ASSERT_ENABLE_BIT];
    end
    // Byte 0: power state
    if (ctrlWrite && cfgByteEn[0])
    begin
      state_d.powerState = cfgWrData[pmc_pkg::POWER_STATE_LSB +: 2];
    end
    // Resume of power wins over a write
    if (powerResume)
    begin
      state_d.powerState = pmc_pkg::PWR_D0;
    end
    // Wake output, active low
    state_d.wakeReq_b = !(wakeFlag.flag
      && (state_q.wakeEnable || magicDefault));
  end

  // State register, power-on reset puts the state at D0
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q.rdData <= 32'h00000000;
      state_q.ack <= 1'b0;
      state_q.wakeReq_b <= 1'b1;
      state_q.powerState <= pmc_pkg::PWR_D0;
      state_q.wakeEnable <= 1'b0;
      state_q.dataSelector <= pmc_pkg::DATA_SELECTOR_RESET;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // Outputs straight from flops
  assign cfgRdData_q = state_q.rdData;
  assign cfgAck_q = state_q.ack;
  assign wakeReq_b_q = state_q.wakeReq_b;
  assign powerState_q = state_q.powerState;
  assign wakeEnable_q = state_q.wakeEnable;
  assign dataSelector_q = state_q.dataSelector;

  // ==========================================================================
  // Assertions
  property p_cap_read;
    @(posedge clk_sys) disable iff (!rst_b)
    (cfgRdEn && cfgAddr == pmc_pkg::PM_CAPABILITIES_OFS)
    |=> (cfgAck_q && cfgRdData_q == 32'hfe820001);
  endproperty
  a_cap_read: assert property (p_cap_read)
    else $error("capabilities word read wrong");

  property p_cap_fields;
    @(posedge clk_sys) disable iff (!rst_b)
    (cfgRdEn && cfgAddr == pmc_pkg::PM_CAPABILITIES_OFS)
    |=> (cfgRdData_q[7:0] == 8'h01 && cfgRdData_q[15:8] == 8'h00
      && cfgRdData_q[18:16] == 3'h2 && !cfgRdData_q[19] && !cfgRdData_q[21]);
  endproperty
  a_cap_fields: assert property (p_cap_fields)
    else $error("capability field value wrong");

  property p_wake_set;
    @(posedge clk_sys) disable iff (!rst_b)
    wakeEvent |=> wakeFlag.flag;
  endproperty
  a_wake_set: assert property (p_wake_set)
    else $error("wake event did not set status");

  property p_wake_clear;
    @(posedge clk_sys) disable iff (!rst_b)
    (wakeFlag.clrReq && !wakeEvent) |=> !wakeFlag.flag ##1 wakeReq_b_q;
  endproperty
  a_wake_clear: assert property (p_wake_clear)
    else $error("write one did not clear wake");

  property p_zero_keeps;
    @(posedge clk_sys) disable iff (!rst_b)
    (wakeFlag.flag && ctrlWrite && !cfgWrData[15]) |=> wakeFlag.flag;
  endproperty
  a_zero_keeps: assert property (p_zero_keeps)
    else $error("write zero changed wake status");

  property p_scale_zero;
    @(posedge clk_sys) disable iff (!rst_b)
    (cfgRdEn && ctrlHit) |=> (cfgRdData_q[14:13] == 2'h0);
  endproperty
  a_scale_zero: assert property (p_scale_zero)
    else $error("data scaling not zero");

  property p_select_store;
    @(posedge clk_sys) disable iff (!rst_b)
    (ctrlWrite && cfgByteEn[1]) |=> (dataSelector_q == $past(cfgWrData[12:9]));
  endproperty
  a_select_store: assert property (p_select_store)
    else $error("data selector not stored");

  property p_wake_blocked;
    @(posedge clk_sys) disable iff (!rst_b)
    (!wakeEnable_q && !magicDefault) |=> wakeReq_b_q;
  endproperty
  a_wake_blocked: assert property (p_wake_blocked)
    else $error("wake asserted while disabled");

  property p_magic_default;
    @(posedge clk_sys) disable iff (!rst_b)
    (wakeFlag.flag && magicDefault) |=> !wakeReq_b_q;
  endproperty
  a_magic_default: assert property (p_magic_default)
    else $error("magic default did not drive wake");

  property p_state_write;
    @(posedge clk_sys) disable iff (!rst_b)
    (ctrlWrite && cfgByteEn[0] && !powerResume) ##1 !(ctrlWrite || powerResume)
      ##1 (cfgRdEn && ctrlHit)
    |=> (cfgRdData_q[1:0] == $past(cfgWrData[1:0], 3));
  endproperty
  a_state_write: assert property (p_state_write)
    else $error("power state not read back");

  property p_resume_d0;
    @(posedge clk_sys) disable iff (!rst_b)
    powerResume |=> (powerState_q == 2'h0);
  endproperty
  a_resume_d0: assert property (p_resume_d0)
    else $error("power state not D0 after resume");

  property p_wake_drive;
    @(posedge clk_sys) disable iff (!rst_b)
    (wakeFlag.flag && wakeEnable_q) |=> !wakeReq_b_q;
  endproperty
  a_wake_drive: assert property (p_wake_drive)
    else $error("wake not driven while enabled");

  property p_ack_pulse;
    @(posedge clk_sys) disable iff (!rst_b)
    (cfgRdEn || cfgWrEn) |=> cfgAck_q;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("access not acknowledged");

  property p_ack_idle;
    @(posedge clk_sys) disable iff (!rst_b)
    !(cfgRdEn || cfgWrEn) |=> !cfgAck_q;
  endproperty
  a_ack_idle: assert property (p_ack_idle)
    else $error("acknowledge without access");

  property p_rd_hold;
    @(posedge clk_sys) disable iff (!rst_b)
    !cfgRdEn |=> $stable(cfgRdData_q);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data changed without a read");

  property p_unmapped_zero;
    @(posedge clk_sys) disable iff (!rst_b)
    (cfgRdEn && cfgAddr != pmc_pkg::PM_CAPABILITIES_OFS && !ctrlHit)
    |=> (cfgRdData_q == 32'h00000000);
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read not zero");

  property p_status_read;
    @(posedge clk_sys) disable iff (!rst_b)
    (cfgRdEn && ctrlHit) |=> (cfgRdData_q[15] == $past(wakeFlag.flag));
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("wake status read wrong");

  property p_status_holds;
    @(posedge clk_sys) disable iff (!rst_b)
    (wakeFlag.flag && !wakeFlag.clrReq) |=> wakeFlag.flag;
  endproperty
  a_status_holds: assert property (p_status_holds)
    else $error("wake status lost without clear");

  property p_ctrl_reserved;
    @(posedge clk_sys) disable iff (!rst_b)
    (cfgRdEn && ctrlHit) |=> (cfgRdData_q[31:16] == 16'h0 && cfgRdData_q[7:2] == 6'h0);
  endproperty
  a_ctrl_reserved: assert property (p_ctrl_reserved)
    else $error("reserved control bits not zero");

  property p_enable_store;
    @(posedge clk_sys) disable iff (!rst_b)
    (ctrlWrite && cfgByteEn[1]) |=> (wakeEnable_q == $past(cfgWrData[8]));
  endproperty
  a_enable_store: assert property (p_enable_store)
    else $error("wake enable not stored");

  property p_state_keep;
    @(posedge clk_sys) disable iff (!rst_b)
    (!(ctrlWrite && cfgByteEn[0]) && !powerResume) |=> $stable(powerState_q);
  endproperty
  a_state_keep: assert property (p_state_keep)
    else $error("power state changed without write");

  // Cover main scenarios
  c_wake_out: cover property (@(posedge clk_sys) disable iff (!rst_b)
    $fell(wakeReq_b_q));
  c_wake_clear: cover property (@(posedge clk_sys) disable iff (!rst_b)
    (wakeFlag.flag && wakeFlag.clrReq && !wakeEvent));
  c_state_d3: cover property (@(posedge clk_sys) disable iff (!rst_b)
    (powerState_q == 2'h3));
  c_set_clear_same: cover property (@(posedge clk_sys) disable iff (!rst_b)
    (wakeEvent && wakeFlag.clrReq));
endmodule
`default_nettype wire

/* File: hdl/pmc_pkg.sv */
/*
  Constants for the power management capability block: register offsets,
  field positions, fixed capability values and reset values.
  Assumes a configuration access port with byte addresses and 32-bit words.
*/
package pmc_pkg;
  // ==========================================================================
  // Register offsets
  localparam logic [7:0] PM_CAPABILITIES_OFS = 8'hc0;
  localparam logic [7:0] PM_CONTROL_STATUS_OFS = 8'hc4;
  // ==========================================================================
  // Capabilities word fields
  localparam logic [4:0] WAKE_STATE_SUPPORT = 5'h1f;
  localparam logic DEEPER_SLEEP_SUPPORTED = 1'h1;
  localparam logic LIGHT_SLEEP_SUPPORTED = 1'h1;
  localparam logic [2:0] AUX_SUPPLY_CURRENT = 3'h2;
  localparam logic SPECIAL_INIT_NEEDED = 1'h0;
  localparam logic WAKE_NEEDS_BUS_CLOCK = 1'h0;
  localparam logic [2:0] PM_SPEC_REVISION = 3'h2;
  localparam logic [7:0] NEXT_CAPABILITY_LINK = 8'h00;
  localparam logic [7:0] CAPABILITY_CODE = 8'h01;
  localparam logic [31:0] PM_CAPABILITIES_RESET = 32'hfe820001;
  // ==========================================================================
  // Control/status word field positions
  localparam int WAKE_STATUS_BIT = 15;
  localparam int DATA_SCALING_LSB = 13;
  localparam int DATA_SELECTOR_LSB = 9;
  localparam int WAKE_ASSERT_ENABLE_BIT = 8;
  localparam int POWER_STATE_LSB = 0;
  localparam logic [1:0] DATA_SCALING_VALUE = 2'h0;
  localparam logic [3:0] DATA_SELECTOR_RESET = 4'h0;
  localparam logic [31:0] PM_CONTROL_STATUS_RESET = 32'h00000000;
  // ==========================================================================
  // Power state encodings
  localparam logic [1:0] PWR_D0 = 2'h0;
  localparam logic [1:0] PWR_D1 = 2'h1;
  localparam logic [1:0] PWR_D2 = 2'h2;
  localparam logic [1:0] PWR_D3HOT = 2'h3;
endpackage

/* File: hdl/pmc_flag_if.sv */
/*
  Carrier for one sticky status flag: set and clear requests in, flag out.
  Assumes owner and user share one clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface pmc_flag_if;
  logic setReq;  // Hardware event, sets the flag
  logic clrReq;  // Software clear request
  logic flag;    // Stored flag
  modport owner (input setReq, input clrReq, output flag);
  modport user (output setReq, output clrReq, input flag);
endinterface
`default_nettype wire

/* File: hdl/pmc_sticky_flag.sv */
/*
  Sticky flag: set by a hardware event, cleared by a software request.
  Assumes requests come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pmc_sticky_flag (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Flag carrier
  pmc_flag_if.owner flagIf
);
  typedef struct packed {
    logic flag;
  } pmc_flag_s;

  pmc_flag_s state_q;  // Registered state
  pmc_flag_s state_d;  // Next state

  // ==========================================================================
  // Next state: set wins over a clear in the same cycle
  always_comb
  begin
    state_d = state_q;
    if (flagIf.clrReq)
    begin
      state_d.flag = 1'b0;
    end
    if (flagIf.setReq)
    begin
      state_d.flag = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign flagIf.flag = state_q.flag;
endmodule
`default_nettype wire

/* File: sim/pmc_host_model.sv */
/*
  Host model: configuration software issuing single-word reads and writes.
  Assumes the block acks each request one cycle after taking it.
*/
`timescale 1ns/1ps
`default_nettype none
module pmc_host_model (
  // Clock
  input wire logic clk_sys,
  // Request lines
  output logic [7:0] cfgAddr,
  output logic cfgRdEn,
  output logic cfgWrEn,
  output logic [3:0] cfgByteEn,
  output logic [31:0] cfgWrData,
  // Answer lines
  input wire logic [31:0] cfgRdData_q,
  input wire logic cfgAck_q
);
  // ==========================================================================
  // Idle lines at time zero
  initial
  begin
    cfgAddr = 8'h00;
    cfgRdEn = 1'b0;
    cfgWrEn = 1'b0;
    cfgByteEn = 4'h0;
    cfgWrData = 32'h0;
  end
  // ==========================================================================
  // One access: enable pulsed one cycle, then a bounded wait for the ack
  task automatic access(input logic wr, input logic [7:0] a, input logic [3:0] be,
    input logic [31:0] d, output logic [31:0] rd, output logic ok);
    int n;
    ok = 1'b0;
    rd = 32'h0;
    @(posedge clk_sys);
    #2;
    cfgAddr = a;
    cfgByteEn = be;
    cfgWrData = d; // Ones clear status, zeros keep it; state bits as given
    cfgRdEn = !wr;
    cfgWrEn = wr;
    @(posedge clk_sys);
    #2;
    cfgRdEn = 1'b0;
    cfgWrEn = 1'b0;
    // Released lines change so stale values never pass
    cfgAddr = ~cfgAddr;
    cfgWrData = ~cfgWrData;
    for (n = 0; n < 4; n++)
    begin
      if (!ok && cfgAck_q === 1'b1)
      begin
        ok = 1'b1;
        rd = cfgRdData_q;
      end
      if (!ok)
      begin
        @(posedge clk_sys);
        #2;
      end
    end
  endtask
endmodule
`default_nettype wire

/* File: sim/pmc_power_mgmt_cap_tb.sv */
/*
  Self-checking bench for the power management capability block.
  Assumes the host model in pmc_host_model and the package constants.
*/
`timescale 1ns/1ps
`default_nettype none
module pmc_power_mgmt_cap_tb;
  // ==========================================================================
  // Signals
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] cfgAddr;
  logic cfgRdEn, cfgWrEn;
  logic [3:0] cfgByteEn;
  logic [31:0] cfgWrData, cfgRdData_q, rd;
  logic cfgAck_q, wakeReq_b_q, wakeEnable_q;
  logic wakeEvent = 1'b0;
  logic cmdMagicBit18 = 1'b0;
  logic cmdMagicBit19 = 1'b0;
  logic powerResume = 1'b0;
  logic [1:0] powerState_q;
  logic [3:0] dataSelector_q;
  logic [31:0] rng = 32'd12;
  int badCount = 0;
  int nCompared = 0;
  int mStat = 0; // Model wake status
  int mEn = 0; // Model wake enable
  int mSel = 0; // Model selector
  int mPwr = 0; // Model power state
  always #25 clk_sys = ~clk_sys;
  // ==========================================================================
  // Design and host
  pmc_power_mgmt_cap i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .cfgAddr(cfgAddr),
    .cfgRdEn(cfgRdEn), .cfgWrEn(cfgWrEn), .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData),
    .cfgRdData_q(cfgRdData_q), .cfgAck_q(cfgAck_q), .wakeEvent(wakeEvent),
    .cmdMagicBit18(cmdMagicBit18), .cmdMagicBit19(cmdMagicBit19),
    .powerResume(powerResume), .wakeReq_b_q(wakeReq_b_q), .powerState_q(powerState_q),
    .wakeEnable_q(wakeEnable_q), .dataSelector_q(dataSelector_q));
  pmc_host_model i_host (.clk_sys(clk_sys), .cfgAddr(cfgAddr), .cfgRdEn(cfgRdEn),
    .cfgWrEn(cfgWrEn), .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData),
    .cfgRdData_q(cfgRdData_q), .cfgAck_q(cfgAck_q));
  // ==========================================================================
  // Helpers
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  // Verdict and end of run
  task automatic conclude();
    $display("Compared %0d, mismatches %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Compare one value
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    nCompared++;
    if (g !== e)
    begin
      badCount++;
      $display("Error: %s expected %h seen %h", name, e, g);
    end
  endtask
  // Port values against the model
  task automatic chkPins();
    logic [31:0] e;
    e = {24'h0, !(mStat[0] && (mEn[0] || (cmdMagicBit18 && cmdMagicBit19))),
      mPwr[1:0], mEn[0], mSel[3:0]};
    chk("ports", e, {24'h0, wakeReq_b_q, powerState_q, wakeEnable_q, dataSelector_q});
  endtask
  // One access; a missing ack ends the run
  task automatic cfg(input logic wr, input logic [7:0] a, input logic [3:0] be,
    input logic [31:0] d);
    logic ok;
    i_host.access(wr, a, be, d, rd, ok);
    if (ok !== 1'b1)
    begin
      badCount++;
      $display("Error: ack expected 1 seen 0");
      conclude();
    end
  endtask
  // Read control/status and compare with the model
  task automatic rdC4();
    cfg(1'b0, pmc_pkg::PM_CONTROL_STATUS_OFS, 4'h0, 32'h0);
    chk("control", {16'h0, mStat[0], 2'h0, mSel[3:0], mEn[0], 6'h0, mPwr[1:0]}, rd);
  endtask
  // Write control/status and update the model lane by lane
  task automatic wrC4(input logic [3:0] be, input logic [31:0] d);
    cfg(1'b1, pmc_pkg::PM_CONTROL_STATUS_OFS, be, d);
    if (be[1] && d[15])
      mStat = 0;
    if (be[1])
    begin
      mSel = d[12:9];
      mEn = d[8];
    end
    if (be[0])
      mPwr = d[1:0];
  endtask
  // Let registered wake output follow
  task automatic settle();
    repeat (2) @(posedge clk_sys);
    #2;
  endtask
  // ==========================================================================
  // Main sequence
  initial
  begin
    repeat (2) @(posedge clk_sys);
    #2;
    rst_b = 1'b1;
    chkPins();
    // Fixed word, ignored write to it, unmapped read
    cfg(1'b0, pmc_pkg::PM_CAPABILITIES_OFS, 4'h0, 32'h0);
    chk("caps", {5'h1f, 2'h3, 3'h2, 3'h0, 3'h2, 8'h00, 8'h01}, rd);
    cfg(1'b1, pmc_pkg::PM_CAPABILITIES_OFS, 4'hf, 32'h0);
    cfg(1'b0, pmc_pkg::PM_CAPABILITIES_OFS, 4'h0, 32'h0);
    chk("caps", {5'h1f, 2'h3, 3'h2, 3'h0, 3'h2, 8'h00, 8'h01}, rd);
    cfg(1'b0, 8'hc8, 4'h0, 32'h0);
    chk("unmapped", 32'h0, rd);
    rdC4();
    $display("Test fixed word done");
    // Random writes; first four set each power state
    for (int i = 0; i < 12; i++)
    begin
      rng = xorshift(rng);
      wrC4((i < 4) ? 4'h1 : rng[7:4], (i < 4) ? {rng[31:2], i[1:0]} : rng);
      rdC4();
      chkPins();
    end
    $display("Test random writes done");
    // Wake with enable off, zero write, enable, clear
    wrC4(4'h3, 32'h0);
    @(posedge clk_sys);
    #2;
    wakeEvent = 1'b1;
    @(posedge clk_sys);
    #2;
    wakeEvent = 1'b0;
    mStat = 1;
    settle();
    rdC4();
    chkPins();
    wrC4(4'h2, 32'h0);
    rdC4();
    wrC4(4'h2, 32'h100);
    settle();
    chkPins();
    wrC4(4'h2, 32'h8100);
    settle();
    chkPins();
    // Event and clear in one cycle: the set wins
    fork
      wrC4(4'h2, 32'h8100);
      begin
        @(posedge clk_sys);
        #2;
        wakeEvent = 1'b1;
        @(posedge clk_sys);
        #2;
        wakeEvent = 1'b0;
      end
    join
    mStat = 1;
    settle();
    rdC4();
    chkPins();
    wrC4(4'h2, 32'h8000);
    settle();
    chkPins();
    $display("Test wake enable done");
    // Magic default enable with enable off
    wrC4(4'h2, 32'h0);
    cmdMagicBit18 = 1'b1;
    cmdMagicBit19 = 1'b1;
    @(posedge clk_sys);
    #2;
    wakeEvent = 1'b1;
    @(posedge clk_sys);
    #2;
    wakeEvent = 1'b0;
    mStat = 1;
    settle();
    chkPins();
    cmdMagicBit19 = 1'b0;
    settle();
    chkPins();
    wrC4(4'h2, 32'h8000);
    cmdMagicBit18 = 1'b0;
    settle();
    chkPins();
    $display("Test magic wake done");
    // Power restored returns to D0
    wrC4(4'h1, 32'h3);
    powerResume = 1'b1;
    @(posedge clk_sys);
    #2;
    powerResume = 1'b0;
    mPwr = 0;
    chkPins();
    rdC4();
    $display("Test power resume done");
    conclude();
  end
endmodule
`default_nettype wire
